// >>> src/acr_pkg.sv
// Constants, register map and types for the converter control block.
// Assumes a plain single-cycle register port with byte-wide registers.
// Operation
// - Control bit 7 picks result justification
// - Left layout: high byte holds bits 9..2
// - Left layout: low byte bits 1,0 top
// - Right layout: high byte holds bits 9,8
// - Channel codes 0-7 external, 1110 DAC
// - Start bit set by software, hardware clears
// - Enable bit 0 powers the converter
// - Bits 6..4 select conversion clock divisor
// - Dedicated oscillator divided by sixteen
// - Bit 0 selects positive reference source
// - Unused clock register bits read zero
// - Clock register clears on every reset
// - Completion clears start, flags, loads result
// - Abort keeps result, waits two periods
package acr_pkg;
   localparam logic [2:0] ADDR_CTRL    = 3'h0;
   localparam logic [2:0] ADDR_CLKREF  = 3'h1;
   localparam logic [2:0] ADDR_RES_HI  = 3'h2;
   localparam logic [2:0] ADDR_RES_LO  = 3'h3;
   localparam logic [2:0] ADDR_IRQ_ST  = 3'h4;
   localparam logic [2:0] ADDR_IRQ_MSK = 3'h5;
   localparam int BIT_JUST  = 7;
   localparam int BIT_START = 1;
   localparam int BIT_EN    = 0;
   localparam int BIT_REF   = 0;
   localparam int CH_LSB    = 2;
   localparam int CS_LSB    = 4;
   localparam logic [7:0] CTRL_WMASK   = 8'hBF;
   localparam logic [7:0] CLKREF_WMASK = 8'h71;
   localparam logic [7:0] RESET_VAL    = 8'h00;
   localparam logic [3:0] CH_DAC       = 4'hE;
   localparam logic [2:0] CS_DEDICATED = 3'h3;
   localparam int RC_DIV       = 16;
   localparam int ABORT_PERIODS = 2;
   localparam int CONV_PERIODS = 11;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CONV  = 2'b01,
      ST_ABORT = 2'b10
   } acr_state_t;
endpackage : acr_pkg

// >>> src/acr_clkdiv.sv
// Conversion clock enable generator.
// Assumes the dedicated oscillator tick is already synchronous to clk.
`timescale 1ns/1ps
module acr_clkdiv import acr_pkg::*; (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] sel,
   input  wire logic       rc_tick,
   // Output
   output logic            tick
);
   logic [5:0] cnt_r;
   logic [3:0] rc_cnt_r;
   logic [5:0] top;

   always_comb begin
      case (sel)
         3'h0:    top = 6'h01;
         3'h4:    top = 6'h03;
         3'h1:    top = 6'h07;
         3'h5:    top = 6'h0F;
         3'h2:    top = 6'h1F;
         3'h6:    top = 6'h3F;
         default: top = 6'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 6'h00;
      end else if (!run || cnt_r >= top) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rc_cnt_r <= 4'h0;
      end else if (!run) begin
         rc_cnt_r <= 4'h0;
      end else if (rc_tick) begin
         rc_cnt_r <= rc_cnt_r + 4'h1;
      end
   end

   always_comb begin
      if (!run) begin
         tick = 1'b0;
      end else if (sel[1:0] == CS_DEDICATED[1:0]) begin
         tick = rc_tick && (rc_cnt_r == 4'(RC_DIV - 1));
      end else begin
         tick = (cnt_r >= top);
      end
   end
endmodule : acr_clkdiv

// >>> src/acr_top.sv
// Register control and sequencing for a 10-bit converter.
// Assumes the conversion core answers with a done pulse and data.
`timescale 1ns/1ps
module acr_top import acr_pkg::*; (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // Dedicated oscillator, asynchronous
   input  wire logic       rc_osc,
   // Conversion core
   input  wire logic       core_done,
   input  wire logic [9:0] core_data,
   output logic            core_power,
   output logic            core_start,
   output logic            core_abort,
   output logic            conv_tick,
   output logic      [3:0] chan_sel,
   output logic            chan_ext,
   output logic            chan_dac,
   output logic            vref_ext,
   // Interrupt
   output logic            irq
);
   logic [7:0] ctrl_r;
   logic [7:0] clkref_r;
   logic [9:0] result_r;
   logic       flag_r;
   logic       mask_r;
   logic       rc_s1_r;
   logic       rc_s2_r;
   logic       rc_s3_r;
   logic       rc_tick;
   logic [1:0] wait_r;
   logic [3:0] conv_cnt_r;
   logic       done_evt;
   logic       sw_abort;
   logic       sw_start;
   acr_state_t state_r;
   logic [7:0] rd_nxt;

   // Oscillator input from another clock; the second and third stages feed edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rc_s1_r <= 1'b0;
         rc_s2_r <= 1'b0;
         rc_s3_r <= 1'b0;
      end else begin
         rc_s1_r <= rc_osc;
         rc_s2_r <= rc_s1_r;
         rc_s3_r <= rc_s2_r;
      end
   end
   assign rc_tick = rc_s2_r & ~rc_s3_r;

   acr_clkdiv u_div (
      .clk     (clk),
      .rst     (rst),
      .run     (ctrl_r[BIT_EN]),
      .sel     (clkref_r[CS_LSB +: 3]),
      .rc_tick (rc_tick),
      .tick    (conv_tick)
   );

   assign sw_start = wr && addr == ADDR_CTRL && wdata[BIT_START]
                     && wdata[BIT_EN] && ctrl_r[BIT_EN];
   assign sw_abort = wr && addr == ADDR_CTRL && !wdata[BIT_START]
                     && state_r == ST_CONV;
   // Core done only counts while running and not being aborted
   assign done_evt = (state_r == ST_CONV) && !sw_abort && ctrl_r[BIT_EN]
                     && (core_done || (conv_tick &&
                         conv_cnt_r == 4'(CONV_PERIODS - 1)));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r    <= ST_IDLE;
         conv_cnt_r <= 4'h0;
         wait_r     <= 2'h0;
      end else if (!ctrl_r[BIT_EN]) begin
         state_r    <= ST_IDLE;
         conv_cnt_r <= 4'h0;
         wait_r     <= 2'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               conv_cnt_r <= 4'h0;
               if (sw_start) begin
                  state_r <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (sw_abort) begin
                  state_r <= ST_ABORT;
                  wait_r  <= 2'h0;
               end else if (done_evt) begin
                  state_r <= ST_IDLE;
               end else if (conv_tick) begin
                  conv_cnt_r <= conv_cnt_r + 4'h1;
               end
            end
            ST_ABORT: begin
               if (conv_tick) begin
                  if (wait_r == 2'(ABORT_PERIODS - 1)) begin
                     state_r <= ST_IDLE;
                  end else begin
                     wait_r <= wait_r + 2'h1;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Control register; start bit mirrors the conversion in progress
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= RESET_VAL;
      end else begin
         if (wr && addr == ADDR_CTRL) begin
            ctrl_r <= wdata & CTRL_WMASK;
            // Start during the abort wait is refused, else the bit sticks
            ctrl_r[BIT_START] <= sw_start && state_r != ST_ABORT;
         end
         if (done_evt) begin
            ctrl_r[BIT_START] <= 1'b0;
         end
         if (!ctrl_r[BIT_EN]) begin
            ctrl_r[BIT_START] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clkref_r <= RESET_VAL;
      end else if (wr && addr == ADDR_CLKREF) begin
         clkref_r <= wdata & CLKREF_WMASK;
      end
   end

   // Result is only replaced on a finished conversion
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_r <= 10'h000;
      end else if (done_evt) begin
         result_r <= core_data;
      end
   end

   // Sticky flag: a new completion wins over the clearing write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if (done_evt) begin
         flag_r <= 1'b1;
      end else if (wr && addr == ADDR_IRQ_ST && wdata[0]) begin
         flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_r <= 1'b0;
      end else if (wr && addr == ADDR_IRQ_MSK) begin
         mask_r <= wdata[0];
      end
   end

   always_comb begin
      rd_nxt = 8'h00;
      case (addr)
         ADDR_CTRL:    rd_nxt = ctrl_r;
         ADDR_CLKREF:  rd_nxt = clkref_r & CLKREF_WMASK;
         ADDR_RES_HI: begin
            if (ctrl_r[BIT_JUST]) begin
               rd_nxt = {6'h00, result_r[9:8]};
            end else begin
               rd_nxt = result_r[9:2];
            end
         end
         ADDR_RES_LO: begin
            if (ctrl_r[BIT_JUST]) begin
               rd_nxt = result_r[7:0];
            end else begin
               rd_nxt = {result_r[1:0], 6'h00};
            end
         end
         ADDR_IRQ_ST:  rd_nxt = {7'h00, flag_r};
         ADDR_IRQ_MSK: rd_nxt = {7'h00, mask_r};
         default:      rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= rd_nxt;
      end else begin
         rdata <= 8'h00;
      end
   end

   assign irq        = flag_r & mask_r;
   assign core_power = ctrl_r[BIT_EN];
   assign core_start = sw_start && state_r == ST_IDLE;
   assign core_abort = sw_abort;
   assign chan_sel   = ctrl_r[CH_LSB +: 4];
   assign chan_ext   = ~ctrl_r[CH_LSB + 3];
   assign chan_dac   = (ctrl_r[CH_LSB +: 4] == CH_DAC);
   assign vref_ext   = clkref_r[BIT_REF];
endmodule : acr_top

// >>> sim/acr_props.sv
// Assertions on the acr_top ports.
// Bound to every acr_top below.
`timescale 1ns/1ps
module acr_props import acr_pkg::*; (
   input wire logic       clk, rst, wr, rd, core_start, core_abort,
   input wire logic       core_power, chan_ext, chan_dac, vref_ext,
   input wire logic [2:0] addr,
   input wire logic [3:0] chan_sel,
   input wire logic [7:0] wdata, rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic wc;
   assign wc = wr && addr == ADDR_CTRL;
   property p_pwr; wc |=> core_power == $past(wdata[0]); endproperty
   a_pwr: assert property (p_pwr) else $error("enable");
   property p_ref;
      wr && addr == ADDR_CLKREF |=> vref_ext == $past(wdata[0]);
   endproperty
   a_ref: assert property (p_ref) else $error("ref");
   property p_ch; wc |=> chan_sel == $past(wdata[5:2]); endproperty
   a_ch: assert property (p_ch) else $error("chan");
   property p_dec;
      chan_dac == (chan_sel == CH_DAC) && chan_ext != chan_sel[3];
   endproperty
   a_dec: assert property (p_dec) else $error("decode");
   property p_go; core_start |-> wc && wdata[BIT_START]; endproperty
   a_go: assert property (p_go) else $error("start");
   property p_gate; core_start |-> core_power && wdata[0]; endproperty
   a_gate: assert property (p_gate) else $error("gate");
   property p_ab; core_abort |-> wc && !wdata[BIT_START]; endproperty
   a_ab: assert property (p_ab) else $error("abort");
   property p_rsv;
      rd && addr == ADDR_CLKREF |=> rdata[7] == 1'h0 && rdata[3:1] == 3'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved");
endmodule : acr_props

bind acr_top acr_props u_props (
   .clk(clk), .rst(rst), .wr(wr), .rd(rd), .core_start(core_start),
   .core_abort(core_abort), .core_power(core_power), .chan_ext(chan_ext),
   .chan_dac(chan_dac), .vref_ext(vref_ext), .addr(addr),
   .chan_sel(chan_sel), .wdata(wdata), .rdata(rdata)
);

// >>> sim/acr_core_model.sv
// Behavioural conversion core.
// Done after 3 periods, 9 when slow.
`timescale 1ns/1ps
module acr_core_model (
   input wire logic       clk, rst, slow, core_power,
   input wire logic       core_start, core_abort, conv_tick,
   input wire logic [9:0] val,
   output logic           core_done,
   output logic     [9:0] core_data
);
   logic       busy;
   logic [3:0] cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {busy, cnt, core_done, core_data} <= '0;
      end else begin
         core_done <= 1'h0;
         // Idle data toggles so a stale capture shows
         core_data <= ~core_data;
         if (core_start) begin
            {busy, cnt} <= 5'h10;
         end else if (core_abort || !core_power) begin
            busy <= 1'h0;
         end else if (busy && conv_tick) begin
            cnt <= cnt + 4'h1;
            if (cnt == (slow ? 4'h8 : 4'h2))
               {busy, core_done, core_data} <= {2'h1, val};
         end
      end
   end
endmodule : acr_core_model

// >>> sim/tb_top.sv
// Self-checking bench for acr_top.
// Core model answers; seeded stimulus.
`timescale 1ns/1ps
module tb_top import acr_pkg::*;;
   logic clk = 1'h0, rc_osc = 1'h0, rst, wr, rd, slow, irq;
   logic core_done, core_power, core_start, core_abort, conv_tick;
   logic chan_ext, chan_dac, vref_ext;
   logic [2:0] addr;
   logic [3:0] chan_sel;
   logic [7:0] wdata, rdata, rv, d, k;
   logic [9:0] core_data, val;
   logic [16:0] lf = 17'h17B91;
   int err_total = 0, n_tests = 0, gap = 0, last_gap = 0;
   acr_top DUT (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .rc_osc(rc_osc), .core_done(core_done),
      .core_data(core_data), .core_power(core_power),
      .core_start(core_start), .core_abort(core_abort),
      .conv_tick(conv_tick), .chan_sel(chan_sel), .chan_ext(chan_ext),
      .chan_dac(chan_dac), .vref_ext(vref_ext), .irq(irq)
   );
   acr_core_model u_core (
      .clk(clk), .rst(rst), .slow(slow), .core_power(core_power),
      .core_start(core_start), .core_abort(core_abort),
      .conv_tick(conv_tick), .val(val), .core_done(core_done),
      .core_data(core_data)
   );
   initial forever #50 clk = ~clk;
   // Unrelated to clk in rate and phase
   initial forever #165 rc_osc = ~rc_osc;
   always @(negedge clk) begin
      gap <= conv_tick ? 1 : gap + 1;
      if (conv_tick)
         last_gap <= gap;
   end
   function automatic logic [16:0] nx(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : nx
   function automatic logic [7:0] res(input logic [9:0] v, input j, h);
      if (h)
         return j ? {6'h00, v[9:8]} : v[9:2];
      return j ? v[7:0] : {v[1:0], 6'h00};
   endfunction : res
   task automatic chk(input logic [9:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %h %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      {wr, addr, wdata} <= {1'h1, a, v};
      @(posedge clk);
      wr <= 1'h0;
      #1;
   endtask : wreg
   task automatic rreg(input logic [2:0] a);
      @(posedge clk);
      {rd, addr} <= {1'h1, a};
      @(posedge clk);
      rd <= 1'h0;
      #1 rv = rdata;
   endtask : rreg
   task automatic rc(input logic [2:0] a, input logic [7:0] e);
      rreg(a);
      chk(rv, e);
   endtask : rc
   task automatic final_report;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   initial begin
      #4000000;
      err_total++;
      final_report;
   end
   initial begin
      rst = 1'h1;
      {wr, rd, slow, addr, wdata, val} = '0;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      rc(ADDR_CTRL, RESET_VAL);
      rc(ADDR_CLKREF, RESET_VAL);
      rc(3'h7, 8'h00);
      for (int i = 0; i < 8; i++) begin
         lf = nx(lf);
         slow <= lf[5];
         val <= i == 0 ? 10'h3FF : i == 1 ? 10'h000 : lf[16:7];
         d = {lf[4], lf[6], i == 0 ? CH_DAC : lf[3:0], 2'h2};
         k = {lf[8], i[2:0], lf[2:0], lf[7]};
         wreg(ADDR_IRQ_MSK, {7'h00, i[0]});
         wreg(ADDR_CLKREF, k);
         rc(ADDR_CLKREF, k & 8'h71);
         wreg(ADDR_CTRL, d);
         d = d & 8'hBC;
         rc(ADDR_CTRL, d);
         wreg(ADDR_CTRL, d | 8'h01);
         wreg(ADDR_CTRL, d | 8'h03);
         rc(ADDR_CTRL, d | 8'h03);
         for (int n = 0; n < 3000 && rv[BIT_START] !== 1'h0; n++)
            rreg(ADDR_CTRL);
         chk(rv, d | 8'h01);
         if (k[5:4] == 2'h3)
            chk(last_gap > 50 && last_gap < 56, 10'h001);
         else
            chk(10'(last_gap), 10'h002 << {k[5:4], k[6]});
         rc(ADDR_RES_HI, res(val, d[7], 1'h1));
         rc(ADDR_RES_LO, res(val, d[7], 1'h0));
         rc(ADDR_IRQ_ST, 8'h01);
         chk(irq, i[0]);
         wreg(ADDR_IRQ_ST, 8'h01);
         chk(irq, 10'h000);
      end
      val <= ~val;
      wreg(ADDR_CLKREF, 8'h60);
      wreg(ADDR_CTRL, 8'h00);
      // Start together with enable in one write must not start
      wreg(ADDR_CTRL, 8'h03);
      rc(ADDR_CTRL, 8'h01);
      wreg(ADDR_CTRL, 8'h03);
      wreg(ADDR_CTRL, 8'h01);
      // Outlasts the internal fallback of 11 periods
      repeat (900) @(posedge clk);
      rc(ADDR_CTRL, 8'h01);
      rc(ADDR_RES_HI, res(~val, 1'h0, 1'h1));
      rc(ADDR_IRQ_ST, 8'h00);
      final_report;
   end
endmodule : tb_top
